// *** dv/fsl_checker.sv ***
/*
 * Port assertions for the command block, bound to every fsl_cmd.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module fsl_checker
    import fsl_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = 1000
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         cs_n_i,
    input  wire logic         quad_enable_flag_i,
    input  wire logic         lock_scheme_select_i,
    input  wire logic         range_protect_i,
    input  wire logic [3:0]   io_oe_o,
    input  wire logic         protect_o,
    input  wire logic         write_latch_flag_o,
    input  wire logic         busy_o,
    input  wire logic         quad_command_mode_o,
    input  wire fsl_rdparam_t read_param_o
);
    logic [31:0] busy_cnt;

    // counts cycles of one self-timed program
    always_ff @(posedge clk_sys_i)
    begin
        busy_cnt <= busy_o ? busy_cnt + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_prog_end;
        $fell(busy_o);
    endsequence
    sequence s_scheme_off;
        !lock_scheme_select_i ##1 !lock_scheme_select_i;
    endsequence

    chk_reset_state:
        assert property ($fell(rst_i) |-> !busy_o && !write_latch_flag_o
            && !quad_command_mode_o && protect_o && read_param_o == RDPARAM_RESET)
        else $error("state after reset not default");
    chk_busy_length:
        assert property (s_prog_end |-> busy_cnt == PROG_CYCLES)
        else $error("program busy length wrong");
    chk_latch_at_end:
        assert property (s_prog_end |-> $fell(write_latch_flag_o))
        else $error("latch not cleared at program end");
    chk_busy_latch:
        assert property (busy_o |-> write_latch_flag_o)
        else $error("program running without latch");
    chk_quad_entry:
        assert property ($rose(quad_command_mode_o) |-> $past(quad_enable_flag_i))
        else $error("quad mode entered without enable");
    chk_param_quad:
        assert property ($changed(read_param_o) |->
            quad_command_mode_o || read_param_o == RDPARAM_RESET)
        else $error("read parameters changed in spi mode");
    chk_mode_keep:
        assert property ($changed(quad_command_mode_o) |->
            ($stable(write_latch_flag_o) && $stable(read_param_o.wrap_size_field))
            || (!write_latch_flag_o && read_param_o == RDPARAM_RESET))
        else $error("mode switch changed latch or wrap");
    chk_oe_mode:
        assert property (io_oe_o == 4'h0 || (io_oe_o == SPI_OE && !quad_command_mode_o)
            || (io_oe_o == QUAD_OE && quad_command_mode_o))
        else $error("drive width does not match mode");
    chk_oe_idle:
        assert property (cs_n_i [*8] |-> io_oe_o == 4'h0)
        else $error("lines driven while deselected");
    chk_busy_quiet:
        assert property (busy_o |-> io_oe_o == 4'h0)
        else $error("read answered while busy");
    chk_scheme_off:
        assert property (s_scheme_off |-> protect_o == $past(range_protect_i))
        else $error("protect ignores range result");
endmodule

bind fsl_cmd fsl_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .quad_enable_flag_i(quad_enable_flag_i), .lock_scheme_select_i(lock_scheme_select_i),
    .range_protect_i(range_protect_i), .io_oe_o(io_oe_o), .protect_o(protect_o),
    .write_latch_flag_o(write_latch_flag_o), .busy_o(busy_o),
    .quad_command_mode_o(quad_command_mode_o), .read_param_o(read_param_o));

// *** dv/fsl_host.sv ***
/*
 * Host side of the serial link: frames, sck periods, bit and nibble shifting.
 * Assumes a 100 MHz clk_sys_i; sck period is 16 of its cycles.
 */
`timescale 1ns/1ps
module fsl_host
    import fsl_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic [3:0] line_i,
    output fsl_pins_t       pins_o
);
    initial pins_o = '{cs_n: 1'b1, sck: 1'b0, io: 4'hf};

    // released lines toggle so stale data never looks valid
    task automatic cyc(input logic rel, input logic [3:0] v, output logic [3:0] r);
        pins_o.io = rel ? ~pins_o.io : v;
        repeat (8) @(negedge clk_sys_i);
        r = line_i;
        pins_o.sck = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        pins_o.sck = 1'b0;
    endtask

    task automatic tx(input logic q, input logic [7:0] b);
        logic [3:0] r;
        if (q)
        begin
            cyc(1'b0, b[7:4], r);
            cyc(1'b0, b[3:0], r);
        end
        else
            for (int i = 7; i >= 0; i--)
                cyc(1'b0, {3'b111, b[i]}, r);
    endtask

    task automatic rx(input logic q, output logic [7:0] b);
        logic [3:0] r;
        b = 8'h00;
        for (int i = 0; i < (q ? 2 : 8); i++)
        begin
            cyc(1'b1, 4'h0, r);
            b = q ? {b[3:0], r} : {b[6:0], r[1]};
        end
    endtask

    task automatic dum(input int n);
        logic [3:0] r;
        repeat (n) cyc(1'b1, 4'h0, r);
    endtask

    task automatic start();
        @(negedge clk_sys_i);
        pins_o.cs_n = 1'b0;
        repeat (8) @(negedge clk_sys_i);
    endtask

    task automatic stop();
        repeat (8) @(negedge clk_sys_i);
        pins_o.cs_n = 1'b1;
        pins_o.io = ~pins_o.io;
        repeat (6) @(negedge clk_sys_i);
    endtask
endmodule

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for fsl_cmd: host model frames and an array stub.
 * Assumes fsl_host and fsl_checker are compiled first.
 */
`timescale 1ns/1ps
module tb_top
    import fsl_pkg::*;
();
    logic         clk_sys_i;
    logic         rst_i;
    fsl_pins_t    pins;
    logic [3:0]   io_o;
    logic [3:0]   io_oe_o;
    logic [3:0]   line;
    logic         qe;
    logic         scheme;
    logic         range_prot;
    logic [2:0]   otp;
    logic [23:0]  array_addr;
    logic [7:0]   array_data;
    logic         protect;
    logic         wlf;
    logic         busy;
    logic         quad;
    fsl_rdparam_t rp;
    int           n_mismatch = 0;
    int           n_tests = 0;
    int           n_cyc = 0;

    assign line = (io_oe_o & io_o) | (~io_oe_o & pins.io);

    fsl_host u_host (.clk_sys_i(clk_sys_i), .line_i(line), .pins_o(pins));

    fsl_cmd #(.PROG_CYCLES(20)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(pins.cs_n), .sck_i(pins.sck),
        .io_i(line), .io_o(io_o), .io_oe_o(io_oe_o), .quad_enable_flag_i(qe),
        .otp_lock_bits_i(otp), .lock_scheme_select_i(scheme), .range_protect_i(range_prot),
        .protect_addr_i(24'h050000), .protect_o(protect), .write_latch_flag_o(wlf),
        .busy_o(busy), .quad_command_mode_o(quad), .read_param_o(rp),
        .array_addr_o(array_addr), .array_data_i(array_data));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // array stub: data is low address byte scrambled
    always @(negedge clk_sys_i) array_data <= array_addr[7:0] ^ 8'h3c;

    always @(posedge clk_sys_i)
    begin
        n_cyc++;
        if (n_cyc == 40000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic g, input logic e);
        chk_v({7'h0, g}, {7'h0, e});
    endtask

    task automatic do_reset();
        rst_i = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk_v({4'h0, rp}, 8'h00);
        chk_v({5'h0, quad, wlf, busy}, 8'h00);
        chk_b(protect, 1'b1);
    endtask

    task automatic addr(input logic q, input logic [23:0] a);
        u_host.tx(q, a[23:16]);
        u_host.tx(q, a[15:8]);
        u_host.tx(q, a[7:0]);
    endtask

    task automatic op(input logic q, input logic [7:0] c, input logic [7:0] d, input logic two);
        u_host.start();
        u_host.tx(q, c);
        if (two)
            u_host.tx(q, d);
        u_host.stop();
    endtask

    task automatic prog(input logic [23:0] a, input logic [7:0] d, input logic eb);
        u_host.start();
        u_host.tx(1'b0, OP_SEC_PROG);
        addr(1'b0, a);
        u_host.tx(1'b0, d);
        u_host.stop();
        chk_b(busy, eb);
        repeat (40) @(negedge clk_sys_i);
        chk_b(busy, 1'b0);
    endtask

    task automatic rd_sec(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] b;
        u_host.start();
        u_host.tx(1'b0, OP_SEC_READ);
        addr(1'b0, a);
        u_host.dum(8);
        u_host.rx(1'b0, b);
        chk_v(b, e0);
        u_host.rx(1'b0, b);
        chk_v(b, e1);
        u_host.stop();
    endtask

    initial
    begin
        logic [7:0] b;
        rst_i = 1'b1;
        qe = 1'b0;
        scheme = 1'b1;
        range_prot = 1'b0;
        otp = 3'h0;
        do_reset();
        scheme = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk_b(protect, 1'b0);
        range_prot = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk_b(protect, 1'b1);
        scheme = 1'b1;
        range_prot = 1'b0;
        op(1'b0, OP_WREN, 8'h00, 1'b0);
        u_host.start();
        u_host.tx(1'b0, OP_BLOCK_LOCK);
        addr(1'b0, 24'h050000);
        u_host.stop();
        chk_b(wlf, 1'b0);
        chk_b(protect, 1'b1);
        prog(24'h002000, 8'h00, 1'b0);
        op(1'b0, OP_WREN, 8'h00, 1'b0);
        prog(24'h0010ff, 8'h3c, 1'b1);
        chk_b(wlf, 1'b0);
        op(1'b0, OP_WREN, 8'h00, 1'b0);
        prog(24'h001000, 8'h81, 1'b1);
        otp = 3'h4;
        op(1'b0, OP_WREN, 8'h00, 1'b0);
        prog(24'h003000, 8'h00, 1'b0);
        prog(24'h001100, 8'h00, 1'b0);
        prog(24'h011000, 8'h00, 1'b0);
        rd_sec(24'h0010ff, 8'h3c, 8'h81);
        rd_sec(24'h002000, 8'hff, 8'hff);
        rd_sec(24'h003000, 8'hff, 8'hff);
        op(1'b0, OP_SET_PARAM, 8'h33, 1'b1);
        chk_v({4'h0, rp}, 8'h00);
        op(1'b0, OP_ENTER_QUAD, 8'h00, 1'b0);
        chk_b(quad, 1'b0);
        qe = 1'b1;
        op(1'b0, OP_ENTER_QUAD, 8'h00, 1'b0);
        chk_b(quad, 1'b1);
        chk_b(wlf, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            op(1'b1, OP_SET_PARAM, {2'b00, 2'(i), 2'b00, 2'(i)}, 1'b1);
            chk_v({4'h0, rp}, {4'h0, 2'(i), 2'(i)});
        end
        u_host.start();
        u_host.tx(1'b1, OP_WRAP_READ);
        addr(1'b1, 24'h00013e);
        u_host.dum(8);
        for (int i = 0; i < 4; i++)
        begin
            u_host.rx(1'b1, b);
            chk_v(b, ((8'h3e + 8'(i)) & 8'h3f) ^ 8'h3c);
        end
        u_host.stop();
        op(1'b1, OP_EXIT_QUAD, 8'h00, 1'b0);
        chk_b(quad, 1'b0);
        chk_v({6'h0, rp.wrap_size_field}, 8'h03);
        chk_b(wlf, 1'b1);
        do_reset();
        tally_and_finish();
    end
endmodule

// *** rtl/fsl_cmd.sv ***
/*
 * Command interpreter for security register program/read, read parameters,
 * wrap read, quad command mode entry/exit and individual block lock.
 * Assumes the serial link pins are asynchronous and much slower than
 * clk_sys_i; status bits and the array read port are on clk_sys_i.
 */
// Function
// - security program accepted only with write latch flag already set
// - program is opcode, 24-bit address, data bytes; up to 256 bytes
// - address upper byte zero, bits 11-8 zero, bits 15-12 pick register
// - locked security register ignores program instructions
// - security read is opcode, 24-bit address, eight dummy clocks
// - read data driven on falling clock edges, msb first
// - byte offset increments and wraps within the register
// - security read ignored while busy, ongoing cycle untouched
// - set read parameters accepted only in quad command mode
// - dummy field selects 2, 4, 6 or 8 dummy clocks
// - wrap field selects 8, 16, 32 or 64 byte wrap length
// - power-up or reset gives 8 byte wrap and 2 dummy clocks
// - wrap read is quad fast read wrapping inside aligned window
// - enter-quad opcode only way in, needs quad enable flag
// - starts in spi mode; spi and quad modes never both active
// - mode switch keeps write latch and wrap length
// - exit-quad opcode returns to spi mode
// - block lock bits protect only while lock scheme select is one
// - block lock bits volatile, all one after power-up or reset
// - block lock is opcode, 24-bit address, chip select high; needs latch
`timescale 1ns/1ps
module fsl_cmd
    import fsl_pkg::*;
#(
    parameter int unsigned PROG_CYCLES   = 1000,
    parameter int unsigned LOCK_BITS     = 64,
    parameter int unsigned LOCK_IDX_LSB  = 16
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         cs_n_i,
    input  wire logic         sck_i,
    input  wire logic [3:0]   io_i,
    output logic      [3:0]   io_o,
    output logic      [3:0]   io_oe_o,
    input  wire logic         quad_enable_flag_i,
    input  wire logic [2:0]   otp_lock_bits_i,
    input  wire logic         lock_scheme_select_i,
    input  wire logic         range_protect_i,
    input  wire logic [23:0]  protect_addr_i,
    output logic              protect_o,
    output logic              write_latch_flag_o,
    output logic              busy_o,
    output logic              quad_command_mode_o,
    output fsl_rdparam_t      read_param_o,
    output logic      [23:0]  array_addr_o,
    input  wire logic [7:0]   array_data_i
);
    localparam int unsigned LW = $clog2(LOCK_BITS);

    if (PROG_CYCLES < 1 || LOCK_BITS < 2 || LOCK_IDX_LSB + LW > 24)
    begin : g_chk
        $error("fsl_cmd: unsupported parameter values");
    end

    fsl_pins_t      pins_raw;
    fsl_pins_t      pins_s;
    fsl_pins_t      pins_q;
    fsl_state_t     state;
    logic [7:0]     cmd;
    logic [5:0]     bits;
    logic [3:0]     clks;
    logic [3:0]     clks_target;
    logic [23:0]    sh;
    logic [23:0]    addr;
    logic           got_data;
    logic [7:0]     osh;
    logic [2:0]     obits;
    logic           rst_en;
    logic [31:0]    prog_cnt;
    logic [31:0]    rst_cnt;
    logic [LOCK_BITS-1:0] lock_bits;
    logic [7:0]     mem_rdata;

    assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, io: io_i};

    fsl_sync #(
        .W       ($bits(fsl_pins_t)),
        .RST_VAL (6'h20)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .d_i       (pins_raw),
        .q_o       (pins_s)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            pins_q <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
        else
            pins_q <= pins_s;
    end

    // edges of the link clock inside a frame, and the chip select rise
    wire sck_rise = pins_s.sck & ~pins_q.sck & ~pins_s.cs_n;
    wire sck_fall = ~pins_s.sck & pins_q.sck & ~pins_s.cs_n;
    wire cs_rise  = pins_s.cs_n & ~pins_q.cs_n;

    wire        quad      = quad_command_mode_o;
    wire [23:0] next_sh   = quad ? {sh[19:0], pins_s.io} : {sh[22:0], pins_s.io[0]};
    wire [5:0]  next_bits = bits + (quad ? 6'h04 : 6'h01);
    wire [7:0]  op        = next_sh[7:0];
    wire        rst_busy  = rst_cnt != 32'h0;
    wire [1:0]  sel       = sec_sel(addr);
    wire [1:0]  next_sel  = sec_sel(next_sh);
    wire        sel_lock  = otp_lock_bits_i[next_sel - 2'h1];
    wire        byte_in   = sck_rise && next_bits == BYTE_BITS;
    wire        addr_in   = sck_rise && next_bits == ADDR_BITS;
    wire        is_wrap   = cmd == OP_WRAP_READ;
    wire [5:0]  wmask     = wrap_mask(read_param_o.wrap_size_field);
    wire [5:0]  wnext     = (addr[5:0] & ~wmask) | ((addr[5:0] + 6'h01) & wmask);
    wire [23:0] next_addr = is_wrap ? {addr[23:6], wnext} : {addr[23:8], addr[7:0] + 8'h01};
    wire        load_byte = state == ST_DOUT && sck_fall && obits == 3'h0;
    wire [7:0]  out_byte  = is_wrap ? array_data_i : mem_rdata;

    // opcode acceptance
    wire acc_prog  = op == OP_SEC_PROG && write_latch_flag_o && !quad;
    wire acc_read  = op == OP_SEC_READ && !quad;
    wire acc_param = op == OP_SET_PARAM && quad;
    wire acc_wrap  = op == OP_WRAP_READ && quad;
    wire acc_lock  = op == OP_BLOCK_LOCK && write_latch_flag_o;
    wire acc_tail  = op == OP_WREN || op == OP_WRDI || op == OP_RST_ENABLE
        || op == OP_RST_DEVICE || (op == OP_ENTER_QUAD && !quad) || (op == OP_EXIT_QUAD && quad);
    wire only_rst  = op == OP_RST_ENABLE || op == OP_RST_DEVICE;
    // while busy only the reset pair is heard
    wire op_block  = rst_busy || (busy_o && !only_rst);

    wire prog_write = state == ST_DIN && byte_in;
    wire done_tail  = cs_rise && state == ST_TAIL;
    wire done_prog  = cs_rise && state == ST_DIN && got_data && bits == 6'h00;
    wire soft_rst   = done_tail && cmd == OP_RST_DEVICE && rst_en;

    fsl_mem #(
        .AW (10)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .wr_i      (prog_write),
        .waddr_i   ({sel, addr[7:0]}),
        .wdata_i   (next_sh[7:0]),
        .raddr_i   ({sel, addr[7:0]}),
        .rdata_o   (mem_rdata)
    );

    // frame sequencer
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || pins_s.cs_n)
        begin
            state    <= ST_OPC;
            bits     <= 6'h00;
            clks     <= 4'h0;
            got_data <= 1'b0;
            if (rst_i)
            begin
                cmd  <= 8'h00;
                sh   <= 24'h0;
                addr <= 24'h0;
                clks_target <= 4'h0;
            end
        end
        else if (sck_rise)
        begin
            sh   <= next_sh;
            bits <= next_bits;
            case (state)
                ST_OPC:
                begin
                    if (next_bits == BYTE_BITS)
                    begin
                        cmd  <= op;
                        bits <= 6'h00;
                        if (op_block)
                            state <= ST_IGNORE;
                        else if (acc_prog || acc_read || acc_wrap || acc_lock)
                            state <= ST_ADDR;
                        else if (acc_param)
                            state <= ST_PARAM;
                        else if (acc_tail)
                            state <= ST_TAIL;
                        else
                            state <= ST_IGNORE;
                    end
                end
                ST_ADDR:
                begin
                    if (next_bits == ADDR_BITS)
                    begin
                        addr <= next_sh;
                        bits <= 6'h00;
                        if (cmd == OP_BLOCK_LOCK)
                            state <= ST_TAIL;
                        else if (cmd == OP_WRAP_READ)
                        begin
                            clks_target <= dummy_clks(read_param_o.dummy_count_field);
                            state       <= ST_DUMMY;
                        end
                        else if (next_sel == 2'h0)
                            state <= ST_IGNORE;
                        else if (cmd == OP_SEC_PROG)
                            state <= sel_lock ? ST_IGNORE : ST_DIN;
                        else
                        begin
                            clks_target <= SEC_DUMMY_CLKS;
                            state       <= ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY:
                begin
                    clks <= clks + 4'h1;
                    bits <= 6'h00;
                    if (clks + 4'h1 == clks_target)
                        state <= ST_DOUT;
                end
                ST_DIN:
                begin
                    if (next_bits == BYTE_BITS)
                    begin
                        bits     <= 6'h00;
                        got_data <= 1'b1;
                        addr     <= next_addr;
                    end
                end
                ST_PARAM:
                begin
                    if (next_bits == BYTE_BITS)
                        state <= ST_TAIL;
                end
                default:
                    bits <= 6'h00;
            endcase
        end
        else if (load_byte)
            addr <= next_addr;
    end

    // read data out on falling edges
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || pins_s.cs_n)
        begin
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
            osh     <= 8'h00;
            obits   <= 3'h0;
            if (rst_i)
                array_addr_o <= 24'h0;
        end
        else
        begin
            if (state == ST_ADDR && addr_in)
                array_addr_o <= next_sh;
            else if (load_byte)
                array_addr_o <= next_addr;
            if (state == ST_DOUT && sck_fall)
            begin
                obits <= obits + (quad ? 3'h4 : 3'h1);
                if (obits == 3'h0)
                begin
                    io_oe_o <= quad ? QUAD_OE : SPI_OE;
                    io_o    <= quad ? out_byte[7:4] : {2'b00, out_byte[7], 1'b0};
                    osh     <= quad ? {out_byte[3:0], 4'h0} : {out_byte[6:0], 1'b0};
                end
                else
                begin
                    io_o <= quad ? osh[7:4] : {2'b00, osh[7], 1'b0};
                    osh  <= quad ? {osh[3:0], 4'h0} : {osh[6:0], 1'b0};
                end
            end
        end
    end

    // mode, latch and parameter state
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || soft_rst)
        begin
            quad_command_mode_o <= 1'b0;
            write_latch_flag_o  <= 1'b0;
            read_param_o        <= RDPARAM_RESET;
            rst_en              <= 1'b0;
        end
        else
        begin
            if (state == ST_PARAM && byte_in)
            begin
                read_param_o.dummy_count_field <= next_sh[DUMMY_MSB:DUMMY_LSB];
                read_param_o.wrap_size_field   <= next_sh[WRAP_MSB:WRAP_LSB];
            end
            if (done_tail)
            begin
                rst_en <= cmd == OP_RST_ENABLE;
                if (cmd == OP_WREN)
                    write_latch_flag_o <= 1'b1;
                if (cmd == OP_WRDI || cmd == OP_BLOCK_LOCK)
                    write_latch_flag_o <= 1'b0;
                // latch and wrap setting deliberately untouched here
                if (cmd == OP_ENTER_QUAD && quad_enable_flag_i)
                    quad_command_mode_o <= 1'b1;
                if (cmd == OP_EXIT_QUAD)
                    quad_command_mode_o <= 1'b0;
            end
            else if (cs_rise)
                rst_en <= 1'b0;
            if (busy_o && prog_cnt == 32'h1)
                write_latch_flag_o <= 1'b0;
        end
    end

    // self-timed program, reset recovery, block locks
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || soft_rst)
        begin
            busy_o    <= 1'b0;
            prog_cnt  <= 32'h0;
            rst_cnt   <= rst_i ? 32'h0 : RST_CYCLES;
            lock_bits <= '1;
            protect_o <= 1'b1;
        end
        else
        begin
            if (rst_busy)
                rst_cnt <= rst_cnt - 32'h1;
            if (done_prog)
            begin
                busy_o   <= 1'b1;
                prog_cnt <= PROG_CYCLES;
            end
            else if (busy_o)
            begin
                prog_cnt <= prog_cnt - 32'h1;
                if (prog_cnt == 32'h1)
                    busy_o <= 1'b0;
            end
            if (done_tail && cmd == OP_BLOCK_LOCK)
                lock_bits[addr[LOCK_IDX_LSB +: LW]] <= 1'b1;
            protect_o <= lock_scheme_select_i ? lock_bits[protect_addr_i[LOCK_IDX_LSB +: LW]]
                                              : range_protect_i;
        end
    end
endmodule

// *** rtl/fsl_mem.sv ***
/*
 * Security register storage: one write port that can only clear bits,
 * one read port with registered data.
 * Assumes programming goes to erased bytes; starts fully erased.
 */
`timescale 1ns/1ps
module fsl_mem #(
    parameter int unsigned AW = 10
) (
    input  wire logic          clk_sys_i,
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    initial
    begin
        for (int i = 0; i < (1 << AW); i++)
            mem[i] = 8'hff;
    end

    // flash cells only go from one to zero
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_i)
            mem[waddr_i] <= mem[waddr_i] & wdata_i;
        rdata_o <= mem[raddr_i];
    end
endmodule

// *** rtl/fsl_pkg.sv ***
/*
 * Shared types, opcodes, field positions, defaults and timing counts of the
 * security-register / quad-mode / block-lock command block.
 * Assumes a single 100 MHz system clock that oversamples the serial link.
 */
package fsl_pkg;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } fsl_pins_t;

    typedef struct packed {
        logic [1:0] dummy_count_field;
        logic [1:0] wrap_size_field;
    } fsl_rdparam_t;

    typedef enum logic [2:0] {
        ST_OPC,
        ST_ADDR,
        ST_DUMMY,
        ST_DIN,
        ST_DOUT,
        ST_PARAM,
        ST_TAIL,
        ST_IGNORE
    } fsl_state_t;

    localparam logic [7:0] OP_WREN       = 8'h06;
    localparam logic [7:0] OP_WRDI       = 8'h04;
    localparam logic [7:0] OP_SEC_PROG   = 8'h42;
    localparam logic [7:0] OP_SEC_READ   = 8'h48;
    localparam logic [7:0] OP_SET_PARAM  = 8'hc0;
    localparam logic [7:0] OP_WRAP_READ  = 8'h0c;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD  = 8'hff;
    localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
    localparam logic [7:0] OP_RST_ENABLE = 8'h66;
    localparam logic [7:0] OP_RST_DEVICE = 8'h99;

    localparam int unsigned DUMMY_MSB      = 5;
    localparam int unsigned DUMMY_LSB      = 4;
    localparam int unsigned WRAP_MSB       = 1;
    localparam int unsigned WRAP_LSB       = 0;
    localparam fsl_rdparam_t RDPARAM_RESET = '{dummy_count_field: 2'h0, wrap_size_field: 2'h0};

    localparam logic [5:0] ADDR_BITS      = 6'h18;
    localparam logic [5:0] BYTE_BITS      = 6'h08;
    localparam logic [3:0] SEC_DUMMY_CLKS = 4'h8;
    localparam logic [3:0] SPI_OE         = 4'h2;
    localparam logic [3:0] QUAD_OE        = 4'hf;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RST_TIME_NS   = 30000;
    localparam int unsigned RST_CYCLES    = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // 1..3 for a valid security register address, 0 otherwise
    function automatic logic [1:0] sec_sel(input logic [23:0] a);
        logic ok;
        ok = (a[23:16] == 8'h00) && (a[11:8] == 4'h0) && (a[15:12] != 4'h0)
            && (a[15:12] <= 4'h3);
        return ok ? a[13:12] : 2'h0;
    endfunction

    // 2, 4, 6 or 8 dummy clocks
    function automatic logic [3:0] dummy_clks(input logic [1:0] f);
        return {1'b0, f, 1'b0} + 4'h2;
    endfunction

    // offset mask inside an 8, 16, 32 or 64 byte window
    function automatic logic [5:0] wrap_mask(input logic [1:0] f);
        return 6'((7'h08 << f) - 7'h01);
    endfunction

endpackage

// *** rtl/fsl_sync.sv ***
/*
 * Two-flop synchroniser for a packed group of pin levels.
 * Assumes the inputs are asynchronous to clk_sys_i and change slowly
 * compared with it.
 */
`timescale 1ns/1ps
module fsl_sync #(
    parameter int unsigned W       = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
